// ### core/omm_defines.vh
// Constants for the optical module management core.
`ifndef OMM_DEFINES_VH
`define OMM_DEFINES_VH

`define OMM_CLK_PERIOD_NS 10

// Seven-bit form of the 8-bit bus address a0.
`define OMM_DEV_ADDR 7'h50

`define OMM_ADDR_STATUS 8'h02
`define OMM_ADDR_LOS_FLAG 8'h03
`define OMM_ADDR_FLT_FLAG 8'h04
`define OMM_ADDR_PWR_CTL 8'h5d
`define OMM_ADDR_LOS_MASK 8'h64
`define OMM_ADDR_FLT_MASK 8'h65
`define OMM_ADDR_PAGE_SEL 8'h7f

`define OMM_BIT_DNR 0
`define OMM_BIT_RDY 1
`define OMM_BIT_SW_PD 1

`define OMM_T_INIT_MS 2000
`define OMM_T_RESET_MIN_US 2

// Reset value of the synchroniser chain: scl, sda, select, reset high.
`define OMM_SYNC_RST 13'h1e00

`endif

// ### core/omm_core.v
// Management logic of a four-lane pluggable optical module.
`timescale 1ns/1ps
`default_nettype none
`include "omm_defines.vh"

module omm_core #(
   parameter integer PAGE_BITS = 2,
   parameter integer INIT_W = 28,
   parameter integer INIT_CYCLES = `OMM_T_INIT_MS * 1000000 / `OMM_CLK_PERIOD_NS
) (
   input wire clk_sys,
   input wire resetn,
   input wire scl_i,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe,
   input wire module_select_n,
   input wire module_reset_n,
   input wire low_power_pin,
   input wire [3:0] los_in,
   input wire [3:0] fault_in,
   output reg interrupt_out_n,
   output reg low_power_out,
   output reg module_ready
);

   localparam integer RST_MIN_CYC =
      (`OMM_T_RESET_MIN_US * 1000 + `OMM_CLK_PERIOD_NS - 1) / `OMM_CLK_PERIOD_NS;
   localparam [7:0] RST_MIN = RST_MIN_CYC[7:0];
   localparam integer INIT_LAST_I = INIT_CYCLES - 1;
   localparam [INIT_W-1:0] INIT_LAST = INIT_LAST_I[INIT_W-1:0];
   localparam integer UP_DEPTH = 1 << (PAGE_BITS + 7);

   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_ADDR = 4'h1;
   localparam [3:0] S_AACK = 4'h2;
   localparam [3:0] S_OFF = 4'h3;
   localparam [3:0] S_OACK = 4'h4;
   localparam [3:0] S_WR = 4'h5;
   localparam [3:0] S_WACK = 4'h6;
   localparam [3:0] S_RD = 4'h7;
   localparam [3:0] S_RACK = 4'h8;

   // Reset release.
   reg [1:0] rsync_reg;
   wire rst_n;

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rsync_reg <= 2'h0;
      end else begin
         rsync_reg <= {rsync_reg[0], 1'b1};
      end
   end

   assign rst_n = rsync_reg[1];

   // Every pin input passes three flops; a change counts once the last two agree.
   wire [12:0] raw;
   reg [12:0] s1_reg;
   reg [12:0] s2_reg;
   reg [12:0] s3_reg;
   reg [12:0] filt_reg;
   reg [12:0] filt_d_reg;

   assign raw = {scl_i, sda_i, module_select_n, module_reset_n, low_power_pin,
                 los_in, fault_in};

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= `OMM_SYNC_RST;
         s2_reg <= `OMM_SYNC_RST;
         s3_reg <= `OMM_SYNC_RST;
         filt_reg <= `OMM_SYNC_RST;
         filt_d_reg <= `OMM_SYNC_RST;
      end else begin
         s1_reg <= raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         filt_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
         filt_d_reg <= filt_reg;
      end
   end

   wire scl = filt_reg[12];
   wire sda = filt_reg[11];
   wire sel = ~filt_reg[10];
   wire mrst_n = filt_reg[9];
   wire lp = filt_reg[8];
   wire [3:0] los = filt_reg[7:4];
   wire [3:0] flt = filt_reg[3:0];
   wire [3:0] los_rise = los & ~filt_d_reg[7:4];
   wire [3:0] flt_rise = flt & ~filt_d_reg[3:0];

   wire scl_rise = scl & ~filt_d_reg[12];
   wire scl_fall = ~scl & filt_d_reg[12];
   wire bus_start = scl & filt_d_reg[12] & filt_d_reg[11] & ~sda;
   wire bus_stop = scl & filt_d_reg[12] & ~filt_d_reg[11] & sda;

   // Module reset pin: short glitches below the minimum pulse are ignored.
   reg [7:0] rcnt_reg;
   reg soft_rst_reg;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rcnt_reg <= 8'h00;
         soft_rst_reg <= 1'b0;
      end else if (mrst_n) begin
         rcnt_reg <= 8'h00;
         soft_rst_reg <= 1'b0;
      end else if (rcnt_reg != RST_MIN) begin
         rcnt_reg <= rcnt_reg + 8'h01;
      end else begin
         soft_rst_reg <= 1'b1;
      end
   end

   // Serial slave.
   reg [3:0] state_reg;
   reg [3:0] bit_cnt_reg;
   reg [7:0] shreg_reg;
   reg [7:0] tx_reg;
   reg [7:0] ptr_reg;
   reg rw_reg;
   reg ackd_reg;
   reg [7:0] rd_data;

   wire sel_ok = sel & ~bus_stop & ~bus_start;
   wire rd_load = sel_ok & scl_fall &
      ((state_reg == S_AACK & rw_reg) | (state_reg == S_RACK & ackd_reg));
   wire wr_byte = sel_ok & scl_fall & (state_reg == S_WR) & (bit_cnt_reg == 4'h8);

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= S_IDLE;
         bit_cnt_reg <= 4'h0;
         shreg_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= 8'h00;
         rw_reg <= 1'b0;
         ackd_reg <= 1'b0;
         sda_oe <= 1'b0;
         sda_o <= 1'b0;
      end else if (soft_rst_reg || !sel || bus_stop) begin
         // Deselect drops the bus at once so the pin is never left held low.
         state_reg <= S_IDLE;
         sda_oe <= 1'b0;
      end else if (bus_start) begin
         state_reg <= S_ADDR;
         bit_cnt_reg <= 4'h0;
         sda_oe <= 1'b0;
      end else if (rd_load) begin
         sda_oe <= ~rd_data[7];
         tx_reg <= {rd_data[6:0], 1'b0};
         ptr_reg <= ptr_reg + 8'h01;
         bit_cnt_reg <= 4'h1;
         state_reg <= S_RD;
      end else begin
         case (state_reg)
            S_ADDR, S_OFF, S_WR: begin
               if (scl_rise) begin
                  shreg_reg <= {shreg_reg[6:0], sda};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                  bit_cnt_reg <= 4'h0;
                  if (state_reg == S_ADDR) begin
                     if (shreg_reg[7:1] == `OMM_DEV_ADDR) begin
                        sda_oe <= 1'b1;
                        rw_reg <= shreg_reg[0];
                        state_reg <= S_AACK;
                     end else begin
                        state_reg <= S_IDLE;
                     end
                  end else if (state_reg == S_OFF) begin
                     ptr_reg <= shreg_reg;
                     sda_oe <= 1'b1;
                     state_reg <= S_OACK;
                  end else begin
                     ptr_reg <= ptr_reg + 8'h01;
                     sda_oe <= 1'b1;
                     state_reg <= S_WACK;
                  end
               end
            end
            S_AACK, S_OACK, S_WACK: begin
               if (scl_fall) begin
                  sda_oe <= 1'b0;
                  bit_cnt_reg <= 4'h0;
                  state_reg <= (state_reg == S_AACK) ? S_OFF : S_WR;
               end
            end
            S_RD: begin
               if (scl_fall) begin
                  if (bit_cnt_reg == 4'h8) begin
                     sda_oe <= 1'b0;
                     state_reg <= S_RACK;
                  end else begin
                     sda_oe <= ~tx_reg[7];
                     tx_reg <= {tx_reg[6:0], 1'b0};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            S_RACK: begin
               if (scl_rise) begin
                  ackd_reg <= ~sda;
               end else if (scl_fall) begin
                  state_reg <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // Memory: lower page plus paged upper space.
   reg [7:0] lower_mem [0:127];
   reg [7:0] upper_mem [0:UP_DEPTH-1];
   reg [PAGE_BITS-1:0] page_reg;
   wire [PAGE_BITS+6:0] up_idx = {page_reg, ptr_reg[6:0]};

   // Control and status state.
   reg dnr_reg;
   reg rdy_flag_reg;
   reg [INIT_W-1:0] init_cnt_reg;
   reg [3:0] los_flag_reg;
   reg [3:0] flt_flag_reg;
   reg [3:0] los_mask_reg;
   reg [3:0] flt_mask_reg;
   reg sw_pd_reg;
   reg [3:0] los_pend_reg;
   reg [3:0] flt_pend_reg;
   reg rdy_pend_reg;

   always @(posedge clk_sys) begin
      if (wr_byte) begin
         if (ptr_reg[7]) begin
            upper_mem[up_idx] <= shreg_reg;
         end else begin
            lower_mem[ptr_reg[6:0]] <= shreg_reg;
         end
      end
   end

   // Live status bytes overlay the lower page so one read gets them all.
   always @* begin
      if (ptr_reg[7]) begin
         rd_data = upper_mem[up_idx];
      end else if (ptr_reg == `OMM_ADDR_STATUS) begin
         rd_data = {6'h00, rdy_flag_reg, dnr_reg};
      end else if (ptr_reg == `OMM_ADDR_LOS_FLAG) begin
         rd_data = {4'h0, los_flag_reg};
      end else if (ptr_reg == `OMM_ADDR_FLT_FLAG) begin
         rd_data = {4'h0, flt_flag_reg};
      end else if (ptr_reg == `OMM_ADDR_PWR_CTL) begin
         rd_data = {6'h00, sw_pd_reg, 1'b0};
      end else if (ptr_reg == `OMM_ADDR_LOS_MASK) begin
         rd_data = {4'h0, los_mask_reg};
      end else if (ptr_reg == `OMM_ADDR_FLT_MASK) begin
         rd_data = {4'h0, flt_mask_reg};
      end else if (ptr_reg == `OMM_ADDR_PAGE_SEL) begin
         rd_data = {{(8 - PAGE_BITS){1'b0}}, page_reg};
      end else begin
         rd_data = lower_mem[ptr_reg[6:0]];
      end
   end

   // Only the bits actually shipped are cleared at stop, so an event raised
   // mid-transfer survives; a new event in the stop cycle also wins.
   wire clr_now = bus_stop;
   wire [3:0] int_src = (los_flag_reg & ~los_mask_reg) | (flt_flag_reg & ~flt_mask_reg);

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n || soft_rst_reg) begin
         if (!rst_n) begin
            interrupt_out_n <= 1'b1;
            low_power_out <= 1'b0;
            module_ready <= 1'b0;
         end
         dnr_reg <= 1'b1;
         rdy_flag_reg <= 1'b0;
         init_cnt_reg <= {INIT_W{1'b0}};
         los_flag_reg <= 4'h0;
         flt_flag_reg <= 4'h0;
         los_mask_reg <= 4'h0;
         flt_mask_reg <= 4'h0;
         sw_pd_reg <= 1'b0;
         page_reg <= {PAGE_BITS{1'b0}};
         los_pend_reg <= 4'h0;
         flt_pend_reg <= 4'h0;
         rdy_pend_reg <= 1'b0;
      end else begin
         if (dnr_reg) begin
            if (init_cnt_reg == INIT_LAST) begin
               dnr_reg <= 1'b0;
               rdy_flag_reg <= 1'b1;
            end else begin
               init_cnt_reg <= init_cnt_reg + {{(INIT_W - 1){1'b0}}, 1'b1};
            end
         end else if (clr_now && rdy_pend_reg) begin
            rdy_flag_reg <= 1'b0;
         end
         los_flag_reg <= (los_flag_reg & ~(los_pend_reg & {4{clr_now}})) | los_rise;
         flt_flag_reg <= (flt_flag_reg & ~(flt_pend_reg & {4{clr_now}})) | flt_rise;
         if (clr_now) begin
            los_pend_reg <= 4'h0;
            flt_pend_reg <= 4'h0;
            rdy_pend_reg <= 1'b0;
         end else if (rd_load) begin
            if (ptr_reg == `OMM_ADDR_LOS_FLAG) begin
               los_pend_reg <= los_pend_reg | los_flag_reg;
            end else if (ptr_reg == `OMM_ADDR_FLT_FLAG) begin
               flt_pend_reg <= flt_pend_reg | flt_flag_reg;
            end else if (ptr_reg == `OMM_ADDR_STATUS) begin
               rdy_pend_reg <= rdy_flag_reg;
            end
         end
         // Control writes take effect at the byte, ahead of the stop.
         if (wr_byte) begin
            if (ptr_reg == `OMM_ADDR_PWR_CTL) begin
               sw_pd_reg <= shreg_reg[`OMM_BIT_SW_PD];
            end else if (ptr_reg == `OMM_ADDR_LOS_MASK) begin
               los_mask_reg <= shreg_reg[3:0];
            end else if (ptr_reg == `OMM_ADDR_FLT_MASK) begin
               flt_mask_reg <= shreg_reg[3:0];
            end else if (ptr_reg == `OMM_ADDR_PAGE_SEL) begin
               page_reg <= shreg_reg[PAGE_BITS-1:0];
            end
         end
         interrupt_out_n <= ~((|int_src) | rdy_flag_reg);
         low_power_out <= lp | sw_pd_reg;
         module_ready <= ~dnr_reg & ~sw_pd_reg;
      end
   end

endmodule

`default_nettype wire

// ### dv/omm_chk.sv
// Pin-level checks on the optical module management core.
`timescale 1ns/1ps
`default_nettype none
module omm_chk #(
   parameter integer INIT_CYCLES = 50
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic module_select_n,
   input wire logic module_reset_n,
   input wire logic low_power_pin,
   input wire logic low_power_out,
   input wire logic module_ready
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   logic [7:0] low_cnt_reg;
   logic [31:0] wait_cnt_reg;
   // The wait count is cleared in low power, since power-down legally holds ready low.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         low_cnt_reg <= 8'h00;
         wait_cnt_reg <= 32'h0;
      end else begin
         if (module_reset_n) low_cnt_reg <= 8'h00;
         else if (low_cnt_reg != 8'hff) low_cnt_reg <= low_cnt_reg + 8'h01;
         if (module_ready || low_power_out || !module_reset_n) wait_cnt_reg <= 32'h0;
         else wait_cnt_reg <= wait_cnt_reg + 32'h1;
      end
   end
   AST_SDA_OPEN_DRAIN: assert property (sda_o == 1'b0)
      else $error("sda data value driven high");
   AST_OE_AT_SCL_LOW: assert property ($rose(sda_oe) |-> !scl_i)
      else $error("sda pulled while serial clock high");
   AST_DESELECT_QUIET: assert property (module_select_n [*8] |-> !sda_oe)
      else $error("sda pulled while not selected");
   AST_LP_PIN_ON: assert property (low_power_pin [*8] |-> low_power_out)
      else $error("low power pin not obeyed");
   AST_LP_OFF_READY: assert property ((!low_power_pin) [*8] ##0 module_ready [*3]
      |-> !low_power_out)
      else $error("low power while ready and pin low");
   AST_INIT_TIME: assert property (wait_cnt_reg <= 32'(INIT_CYCLES + 20))
      else $error("not ready within init time");
   AST_LONG_RESET: assert property ($rose(module_reset_n) && low_cnt_reg > 8'hd2
      |-> ##[1:10] !module_ready)
      else $error("long module reset ignored");
   AST_SHORT_RESET: assert property ($rose(module_reset_n) && low_cnt_reg < 8'hb4
      && module_ready |-> ##1 module_ready [*8])
      else $error("short module reset acted on");
endmodule
bind omm_core omm_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
   .clk_sys(clk_sys), .resetn(resetn), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .module_select_n(module_select_n), .module_reset_n(module_reset_n),
   .low_power_pin(low_power_pin), .low_power_out(low_power_out),
   .module_ready(module_ready));
`default_nettype wire

// ### dv/omm_host.sv
// Behavioural two-wire bus master standing on the host side of the module.
`timescale 1ns/1ps
`default_nettype none
module omm_host (
   input wire logic clk_sys,
   input wire logic sda,
   output logic scl,
   output logic sda_oe
);
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // One bit is 16 clocks, a 160 ns serial clock; data moves only while scl is low.
   task automatic bitx(input logic b, output logic r);
      scl <= 1'b0;
      tick(4);
      sda_oe <= ~b;
      tick(4);
      scl <= 1'b1;
      tick(4);
      r = sda;
      tick(4);
   endtask
   // Start when s is high, stop when low; scl then idles high.
   task automatic frame(input logic s);
      scl <= 1'b0;
      tick(4);
      sda_oe <= !s;
      tick(4);
      scl <= 1'b1;
      tick(8);
      sda_oe <= s;
      tick(8);
   endtask
   task automatic wb(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask
   task automatic wr(input logic [7:0] off, input logic [7:0] d);
      logic a;
      frame(1'b1);
      wb(8'ha0, a);
      wb(off, a);
      wb(d, a);
      frame(1'b0);
   endtask
   task automatic rd(input logic [7:0] off, output logic [7:0] d);
      logic a;
      frame(1'b1);
      wb(8'ha0, a);
      wb(off, a);
      frame(1'b1);
      wb(8'ha1, a);
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, a);
         d[i] = a;
      end
      bitx(1'b1, a);
      frame(1'b0);
   endtask
   task automatic probe(input logic [7:0] adr, output logic a);
      frame(1'b1);
      wb(adr, a);
      frame(1'b0);
   endtask
endmodule
`default_nettype wire

// ### dv/test_optical_module_management.sv
// Self-checking bench for the optical module management core.
`timescale 1ns/1ps
`default_nettype none
`include "omm_defines.vh"
module test_optical_module_management;
   localparam int INIT = 50;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic module_select_n = 1'b0;
   logic module_reset_n = 1'b1;
   logic low_power_pin = 1'b0;
   logic [3:0] los_in = 4'h0;
   logic [3:0] fault_in = 4'h0;
   wire scl, host_oe, sda_oe, interrupt_out_n, low_power_out, module_ready;
   // Pulled-up open-drain line shared by host and module.
   wire sda = ~(host_oe | sda_oe);
   int mismatches = 0;
   int tests_run = 0;
   integer seed = 32'hcaaca2df;
   always #5 clk_sys = ~clk_sys;
   omm_core #(.INIT_CYCLES(INIT)) uut (
      .clk_sys(clk_sys), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(),
      .sda_oe(sda_oe), .module_select_n(module_select_n),
      .module_reset_n(module_reset_n), .low_power_pin(low_power_pin), .los_in(los_in),
      .fault_in(fault_in), .interrupt_out_n(interrupt_out_n),
      .low_power_out(low_power_out), .module_ready(module_ready));
   omm_host u_host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_oe(host_oe));
   function automatic logic [7:0] pat(input int p);
      return 8'h5a ^ 8'(p);
   endfunction
   task automatic conclude();
      if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_rdy();
      for (int i = 0; i < INIT + 40; i++) begin
         if (module_ready === 1'b1) return;
         @(posedge clk_sys);
      end
      mismatches++;
      conclude();
   endtask
   initial begin
      logic [7:0] d;
      logic [3:0] x;
      logic a;
      repeat (5) @(posedge clk_sys);
      chk({module_ready, interrupt_out_n, low_power_out, sda_oe}, 8'h04);
      resetn <= 1'b1;
      wait_rdy();
      u_host.tick(3);
      chk(interrupt_out_n, 1'b0);
      u_host.rd(`OMM_ADDR_STATUS, d);
      chk(d[1:0], 2'b10);
      chk(interrupt_out_n, 1'b1);
      d = 8'($random(seed));
      x = d[3:0] | 4'h1;
      los_in <= x;
      low_power_pin <= d[7];
      u_host.tick(8);
      chk(interrupt_out_n, 1'b0);
      chk(low_power_out, d[7]);
      u_host.rd(`OMM_ADDR_LOS_FLAG, d);
      chk(d, {4'h0, x});
      chk(interrupt_out_n, 1'b1);
      u_host.rd(`OMM_ADDR_LOS_FLAG, d);
      chk(d, 8'h00);
      los_in <= 4'h0;
      u_host.wr(`OMM_ADDR_FLT_MASK, 8'h0f);
      x = 4'($random(seed)) | 4'h8;
      fault_in <= x;
      u_host.tick(10);
      chk(interrupt_out_n, 1'b1);
      u_host.wr(`OMM_ADDR_FLT_MASK, 8'h00);
      chk(interrupt_out_n, 1'b0);
      u_host.rd(`OMM_ADDR_FLT_FLAG, d);
      chk(d, {4'h0, x});
      chk(interrupt_out_n, 1'b1);
      fault_in <= 4'h0;
      u_host.wr(`OMM_ADDR_LOS_FLAG, 8'hff);
      u_host.rd(`OMM_ADDR_LOS_FLAG, d);
      chk(d, 8'h00);
      for (int p = 1; p < 4; p++) begin
         u_host.wr(`OMM_ADDR_PAGE_SEL, 8'(p));
         u_host.wr(8'h80, pat(p));
      end
      for (int p = 3; p > 0; p--) begin
         u_host.wr(`OMM_ADDR_PAGE_SEL, 8'(p));
         u_host.rd(8'h80, d);
         chk(d, pat(p));
      end
      u_host.probe(8'ha2, a);
      chk(a, 1'b0);
      module_select_n <= 1'b1;
      u_host.tick(20);
      u_host.probe(8'ha0, a);
      chk(a, 1'b0);
      module_select_n <= 1'b0;
      u_host.tick(20);
      u_host.probe(8'ha0, a);
      chk(a, 1'b1);
      low_power_pin <= 1'b1;
      u_host.tick(10);
      chk(low_power_out, 1'b1);
      low_power_pin <= 1'b0;
      u_host.tick(10);
      u_host.wr(`OMM_ADDR_PWR_CTL, 8'h02);
      chk({low_power_out, module_ready}, 2'b10);
      u_host.wr(`OMM_ADDR_PWR_CTL, 8'h00);
      chk({low_power_out, module_ready}, 2'b01);
      module_reset_n <= 1'b0;
      u_host.tick(100 + ($random(seed) & 63));
      module_reset_n <= 1'b1;
      u_host.tick(10);
      u_host.rd(`OMM_ADDR_PAGE_SEL, d);
      chk(d, 8'h01);
      module_reset_n <= 1'b0;
      u_host.tick(220 + ($random(seed) & 31));
      module_reset_n <= 1'b1;
      u_host.tick(10);
      chk(module_ready, 1'b0);
      wait_rdy();
      u_host.tick(3);
      chk(interrupt_out_n, 1'b0);
      u_host.rd(`OMM_ADDR_PAGE_SEL, d);
      chk(d, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
